/* shared/adc_ctrl_pkg.sv */
// Package with register map, field layout and timing constants of the converter control.
`default_nettype none
package adc_ctrl_pkg;
    // Register byte offsets on APB.
    localparam logic [7:0] OFF_RESULT_LOW  = 8'h00;
    localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
    localparam logic [7:0] OFF_CTRL_A      = 8'h08;
    localparam logic [7:0] OFF_CTRL_B      = 8'h0c;
    localparam logic [7:0] OFF_CHAN_REF    = 8'h10;
    localparam logic [7:0] OFF_POWER      = 8'h14;
    localparam logic [7:0] OFF_ANALOG     = 8'h18;
    // Control A fields.
    localparam int CA_DIV_LSB   = 0;
    localparam int CA_IRQ_EN    = 3;
    localparam int CA_DONE      = 4;
    localparam int CA_AUTO      = 5;
    localparam int CA_START     = 6;
    localparam int CA_ENABLE    = 7;
    // Channel and reference fields.
    localparam int CR_CHAN_LSB  = 0;
    localparam int CR_LEFT      = 5;
    localparam int CR_REF_LSB   = 6;
    // Control B and power fields.
    localparam int CB_TRIG_LSB  = 0;
    localparam int PW_OFF       = 0;
    // Timing in converter clocks, counted in half cycles.
    localparam logic [5:0] HALF_NORMAL_END   = 6'd26;
    localparam logic [5:0] HALF_FIRST_END    = 6'd50;
    localparam logic [5:0] HALF_NORMAL_SAMP  = 6'd3;
    localparam logic [5:0] HALF_FIRST_SAMP   = 6'd27;
    localparam logic [5:0] HALF_AUTO_SAMP    = 6'd4;
    localparam logic [5:0] HALF_AUTO_END     = 6'd27;
    localparam logic [2:0] TRIG_FREE_RUN     = 3'h0;
    localparam logic [31:0] RESET_VALUE      = 32'h0000_0000;
    typedef struct packed {
        logic [1:0] reference;
        logic [4:0] channel;
    } selection_t;
endpackage
`default_nettype wire

/* rtl/adc_prescaler.sv */
// Clock prescaler giving one-cycle half-period ticks of the converter clock.
`default_nettype none
module adc_prescaler (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] div_select,
    // Ticks
    output logic            rise_tick,
    output logic            fall_tick
);
    logic [6:0] count;
    logic [6:0] half;
    logic       phase;

    // Division 2^n with codes 0 and 1 both giving two.
    always_comb begin
        half = (div_select <= 3'h1) ? 7'h01 : 7'(7'h01 << (div_select - 3'h1));
    end

    // Held in reset while disabled or restarted by a trigger.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 7'h00;
            phase <= 1'b0;
        end else if (!run || restart) begin
            count <= 7'h00;
            phase <= 1'b0;
        end else if (count + 7'h01 >= half) begin
            count <= 7'h00;
            phase <= ~phase;
        end else begin
            count <= count + 7'h01;
        end
    end

    assign rise_tick = run && !restart && (count + 7'h01 >= half) && !phase;
    assign fall_tick = run && !restart && (count + 7'h01 >= half) && phase;
endmodule
`default_nettype wire

/* rtl/adc_conversion_control.sv */
// Conversion control of a 10-bit successive-approximation converter with an APB slave.
// Notes on behaviour
// - Code zero is ground; full code is reference minus one step.
// - Selections reach the converter only once the enable bit is set.
// - Result right-justified by default, left-justified when left adjust is set.
// - Low byte read locks both result bytes; completions meanwhile are lost.
// - High byte read unlocks result updates.
// - Done flag sets at every conversion end, even when the result is lost.
// - Start bit launches a conversion, stays one, clears when single conversion ends.
// - Channel change mid conversion applies only after it.
// - Auto trigger rising edge resets the prescaler and starts a conversion.
// - Trigger edges in a conversion are ignored; a held level starts nothing.
// - Trigger flags set regardless of enables; software clears before next event.
// - Done flag as trigger restarts at each end; first needs the start bit.
// - Start bit works under auto trigger and reads one in any conversion.
// - Prescaler divides by the selected ratio and is held reset when disabled.
// - A start bit write begins on the next converter clock rising edge.
// - Normal conversion 13 cycles, first after enable 25 cycles.
// - Sampling at 1.5 cycles normally and 13.5 in a first conversion.
// - At end write result, set done flag, clear start bit in single mode.
// - Auto-triggered: sample two cycles after edge, 13.5 cycles total.
// - Free running starts the next conversion at once, start bit stays set.
// - Converter stays disabled unless the power-off bit is zero.
// - Selections copy while idle, freeze in conversion, resume in last cycle.
//
// Added by the designer: the APB interface to the registers and the register addresses.
`default_nettype none
module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int TRIG_COUNT = 8
) (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Trigger inputs, taken as synchronous; index zero is unused for free run
    input  wire logic [TRIG_COUNT-1:0] trigger_in,
    // Analog converter side
    input  wire logic [9:0]            analog_code,
    output adc_ctrl_pkg::selection_t   analog_select,
    output logic                       analog_power,
    output logic                       sample_hold,
    output logic                       conversion_done
);
    import adc_ctrl_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ARMED   = 2'b01,
        ST_CONVERT = 2'b10
    } conv_state_t;

    conv_state_t state;
    logic        converter_enable;
    logic        conversion_start_bit;
    logic        auto_trigger_enable;
    logic        conversion_done_flag;
    logic        conversion_irq_enable;
    logic [2:0]  clock_divider_select;
    logic [2:0]  trigger_source_select;
    selection_t  holding_select;
    logic        left_adjust_select;
    logic        converter_power_off;
    logic [9:0]  result;
    logic        result_locked;
    logic        first_pending;
    logic        auto_started;
    logic [5:0]  half_count;
    logic        trig_prev;
    logic        trig_level;
    logic        trig_edge;
    logic        rise_tick;
    logic        fall_tick;
    logic        active;
    logic        wr_en;
    logic        rd_en;
    logic        end_now;
    logic [5:0]  end_half;
    logic [5:0]  samp_half;
    logic        start_write;

    assign active      = converter_enable && !converter_power_off;
    assign wr_en       = psel && penable && pwrite;
    assign rd_en       = psel && penable && !pwrite;
    assign start_write = wr_en && paddr == OFF_CTRL_A && pwdata[CA_START];

    // Free-run source is the done flag itself; other codes pick an input.
    assign trig_level = (trigger_source_select == TRIG_FREE_RUN) ? conversion_done_flag
                      : trigger_in[trigger_source_select];
    assign trig_edge  = trig_level && !trig_prev;

    adc_prescaler u_prescaler (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (active),
        .restart    (trig_edge && auto_trigger_enable && state != ST_CONVERT &&
                     trigger_source_select != TRIG_FREE_RUN),
        .div_select (clock_divider_select),
        .rise_tick  (rise_tick),
        .fall_tick  (fall_tick)
    );

    always_comb begin
        if (first_pending) begin
            end_half  = HALF_FIRST_END;
            samp_half = HALF_FIRST_SAMP;
        end else if (auto_started) begin
            end_half  = HALF_AUTO_END;
            samp_half = HALF_AUTO_SAMP;
        end else begin
            end_half  = HALF_NORMAL_END;
            samp_half = HALF_NORMAL_SAMP;
        end
    end

    assign end_now = state == ST_CONVERT && (rise_tick || fall_tick) &&
                     half_count + 6'd1 >= end_half;

    // Trigger edge history.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_level;
        end
    end

    // Conversion sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= ST_IDLE;
            half_count   <= 6'd0;
            auto_started <= 1'b0;
        end else if (!active) begin
            state        <= ST_IDLE;
            half_count   <= 6'd0;
            auto_started <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (auto_trigger_enable && trig_edge &&
                        trigger_source_select != TRIG_FREE_RUN) begin
                        state        <= ST_CONVERT;
                        half_count   <= 6'd0;
                        auto_started <= !first_pending;
                    end else if (start_write) begin
                        state        <= ST_ARMED;
                        auto_started <= 1'b0;
                    end
                end
                ST_ARMED: begin
                    if (rise_tick) begin
                        state      <= ST_CONVERT;
                        half_count <= 6'd0;
                    end
                end
                ST_CONVERT: begin
                    if (end_now) begin
                        half_count <= 6'd0;
                        if (auto_trigger_enable && trigger_source_select == TRIG_FREE_RUN) begin
                            state        <= ST_CONVERT;
                            auto_started <= 1'b0;
                        end else if (start_write) begin
                            // A start write in the end cycle keeps the start bit set, so re-arm.
                            state        <= ST_ARMED;
                            auto_started <= 1'b0;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (rise_tick || fall_tick) begin
                        half_count <= half_count + 6'd1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // First conversion after enabling takes the long path.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_pending <= 1'b1;
        end else if (!active) begin
            first_pending <= 1'b1;
        end else if (end_now) begin
            first_pending <= 1'b0;
        end
    end

    // Sample instant and completion pulse toward the analog side.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_hold     <= 1'b0;
            conversion_done <= 1'b0;
        end else begin
            sample_hold     <= state == ST_CONVERT && (rise_tick || fall_tick) &&
                               half_count + 6'd1 == samp_half;
            conversion_done <= end_now;
        end
    end

    // Selections copy while idle or armed and in the last cycle; frozen otherwise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_select <= '0;
        end else if (active && (state != ST_CONVERT ||
                                half_count + 6'd2 >= end_half)) begin
            analog_select <= holding_select;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_power <= 1'b0;
        end else begin
            analog_power <= active;
        end
    end

    // Result register with the read interlock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result <= 10'h000;
        end else if (end_now && !result_locked) begin
            result <= analog_code;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_locked <= 1'b0;
        end else if (rd_en && paddr == OFF_RESULT_HIGH) begin
            result_locked <= 1'b0;
        end else if (rd_en && paddr == OFF_RESULT_LOW) begin
            result_locked <= 1'b1;
        end
    end

    // Control A. Done flag: set wins over the write-one clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_enable      <= 1'b0;
            auto_trigger_enable   <= 1'b0;
            conversion_irq_enable <= 1'b0;
            clock_divider_select  <= 3'h0;
            conversion_done_flag  <= 1'b0;
        end else begin
            if (wr_en && paddr == OFF_CTRL_A) begin
                converter_enable      <= pwdata[CA_ENABLE];
                auto_trigger_enable   <= pwdata[CA_AUTO];
                conversion_irq_enable <= pwdata[CA_IRQ_EN];
                clock_divider_select  <= pwdata[CA_DIV_LSB +: 3];
            end
            if (end_now) begin
                conversion_done_flag <= 1'b1;
            end else if (wr_en && paddr == OFF_CTRL_A && pwdata[CA_DONE]) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // Start bit reads one while armed or converting.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conversion_start_bit <= 1'b0;
        end else if (!active) begin
            conversion_start_bit <= 1'b0;
        end else if (start_write || (state == ST_IDLE && auto_trigger_enable &&
                     trig_edge && trigger_source_select != TRIG_FREE_RUN)) begin
            conversion_start_bit <= 1'b1;
        end else if (end_now && !(auto_trigger_enable &&
                     trigger_source_select == TRIG_FREE_RUN)) begin
            conversion_start_bit <= 1'b0;
        end
    end

    // Other writable registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_source_select <= 3'h0;
            holding_select        <= '0;
            left_adjust_select    <= 1'b0;
            converter_power_off   <= 1'b0;
        end else if (wr_en) begin
            if (paddr == OFF_CTRL_B) begin
                trigger_source_select <= pwdata[CB_TRIG_LSB +: 3];
            end
            if (paddr == OFF_CHAN_REF) begin
                holding_select.channel   <= pwdata[CR_CHAN_LSB +: 5];
                holding_select.reference <= pwdata[CR_REF_LSB +: 2];
                left_adjust_select       <= pwdata[CR_LEFT];
            end
            if (paddr == OFF_POWER) begin
                converter_power_off <= pwdata[PW_OFF];
            end
        end
    end

    // APB read data, registered in the setup cycle; no wait states.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= RESET_VALUE;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > OFF_ANALOG;
            if (psel && !penable) begin
                unique case (paddr)
                    OFF_RESULT_LOW:  prdata <= left_adjust_select ?
                                         {24'h0, result[1:0], 6'h00} :
                                         {24'h0, result[7:0]};
                    OFF_RESULT_HIGH: prdata <= left_adjust_select ?
                                         {24'h0, result[9:2]} :
                                         {30'h0, result[9:8]};
                    OFF_CTRL_A:      prdata <= {24'h0, converter_enable,
                                         conversion_start_bit, auto_trigger_enable,
                                         conversion_done_flag, conversion_irq_enable,
                                         clock_divider_select};
                    OFF_CTRL_B:      prdata <= {29'h0, trigger_source_select};
                    OFF_CHAN_REF:    prdata <= {24'h0, holding_select.reference,
                                         left_adjust_select, holding_select.channel};
                    OFF_POWER:       prdata <= {31'h0, converter_power_off};
                    OFF_ANALOG:      prdata <= {22'h0, state, first_pending,
                                         result_locked, 1'b0, analog_select.channel};
                    default:         prdata <= RESET_VALUE;
                endcase
            end
        end
    end

    a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
        result_locked && !(rd_en && paddr == OFF_RESULT_HIGH) |=> $stable(result))
        else $error("Result changed while locked.");
    a_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
        end_now |=> conversion_done_flag)
        else $error("Done flag not set at end.");
    a_start_busy: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_CONVERT |-> conversion_start_bit)
        else $error("Start bit low during conversion.");
    a_freeze_sel: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_CONVERT && half_count + 6'd2 < end_half && !$rose(state == ST_CONVERT)
        |=> $stable(analog_select) || !active)
        else $error("Selection moved mid conversion.");
    a_power_gate: assert property (@(posedge pclk) disable iff (!presetn)
        converter_power_off |=> state == ST_IDLE && !analog_power)
        else $error("Converter ran while powered off.");
    a_unlock_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == OFF_RESULT_HIGH |=> !result_locked)
        else $error("High byte read did not unlock.");
    a_armed_wait: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_ARMED && active && !rise_tick |=> state == ST_ARMED)
        else $error("Conversion began off the clock edge.");
    a_single_clear: assert property (@(posedge pclk) disable iff (!presetn)
        end_now && !auto_trigger_enable && !start_write |=> !conversion_start_bit)
        else $error("Start bit not cleared at end.");
endmodule
`default_nettype wire

/* verification/analog_front_model.sv */
// Behavioural model of the analog multiplexer and converter behind the control block.
`default_nettype none
module analog_front_model
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // Control side
    input  wire adc_ctrl_pkg::selection_t analog_select,
    input  wire logic                     analog_power,
    input  wire logic                     sample_hold,
    input  wire logic                     conversion_done,
    // Result
    output logic [9:0]                    analog_code
);
    logic [9:0] held;
    logic       valid;

    // Outside a conversion the code toggles every cycle, so a capture at the wrong time shows.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held  <= 10'h000;
            valid <= 1'b0;
        end else if (sample_hold && analog_power) begin
            held  <= {analog_select.channel, 5'h0b};
            valid <= 1'b1;
        end else if (conversion_done) begin
            valid <= 1'b0;
        end else if (!valid) begin
            held <= ~held;
        end
    end
    assign analog_code = held;
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Self-checking testbench of the converter conversion control.
`default_nettype none
module testbench;
    import adc_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic       pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic       analog_power, sample_hold, conversion_done;
    logic [7:0] paddr, trigger_in;
    logic [31:0] pwdata, prdata, r;
    logic [9:0] analog_code;
    selection_t analog_select;
    int         fails, total_checks, n, s;

    adc_conversion_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
        .analog_code(analog_code), .analog_select(analog_select),
        .analog_power(analog_power), .sample_hold(sample_hold),
        .conversion_done(conversion_done));
    analog_front_model model (.pclk(pclk), .presetn(presetn),
        .analog_select(analog_select), .analog_power(analog_power),
        .sample_hold(sample_hold), .conversion_done(conversion_done),
        .analog_code(analog_code));

    always #5 pclk = ~pclk;

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) begin
            fails++;
            $display("BAD apb ready expected 1 seen %b", pready);
        end
        r   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Counts clock edges until the completion pulse, bounded so a dead converter is seen.
    task automatic wait_done;
        n = 0;
        s = 0;
        do begin
            @(posedge pclk);
            n++;
            if (sample_hold === 1'b1) begin
                s = n;
            end
        end while (conversion_done !== 1'b1 && n < 400);
        if (conversion_done !== 1'b1) begin
            fails++;
            $display("BAD conversion done expected 1 seen %b", conversion_done);
        end
    endtask

    task automatic s_reset;
        apb(OFF_CTRL_A, 1'b0, 32'h0);
        check("ctrl a reset", RESET_VALUE, r);
        apb(8'h1c, 1'b0, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
    endtask

    task automatic s_select;
        apb(OFF_CHAN_REF, 1'b1, 32'h03);
        check("select while off", 32'h0, analog_select);
        apb(OFF_POWER, 1'b1, 32'h1);
        apb(OFF_CTRL_A, 1'b1, 32'h81);
        apb(OFF_CTRL_A, 1'b0, 32'h0);
        check("power while off bit", 32'h0, {31'h0, analog_power});
        apb(OFF_POWER, 1'b1, 32'h0);
        apb(OFF_CTRL_A, 1'b0, 32'h0);
        check("power on", 32'h1, {31'h0, analog_power});
        check("select applied", 32'h03, analog_select);
    endtask

    task automatic s_first;
        apb(OFF_CTRL_A, 1'b1, 32'hc1);
        wait_done;
        check("first length", 32'h1, (n >= 50 && n <= 56));
        check("first sample", {26'h0, HALF_FIRST_END - HALF_FIRST_SAMP}, n - s);
        apb(OFF_CTRL_A, 1'b0, 32'h0);
        check("start and done", 32'h1, {r[CA_START], r[CA_DONE]});
        apb(OFF_RESULT_LOW, 1'b0, 32'h0);
        check("right low", 32'h6b, r);
        apb(OFF_RESULT_HIGH, 1'b0, 32'h0);
        check("right high", 32'h00, r);
    endtask

    task automatic s_left;
        apb(OFF_CHAN_REF, 1'b1, 32'h23);
        apb(OFF_CTRL_A, 1'b1, 32'hd1);
        apb(OFF_CTRL_A, 1'b0, 32'h0);
        check("start busy", 32'h1, r[CA_START]);
        wait_done;
        check("normal length", 32'h1, (n >= 20 && n <= 32));
        check("normal sample", {26'h0, HALF_NORMAL_END - HALF_NORMAL_SAMP}, n - s);
        apb(OFF_RESULT_LOW, 1'b0, 32'h0);
        check("left low", 32'hc0, r);
    endtask

    task automatic s_lock;
        apb(OFF_CHAN_REF, 1'b1, 32'h25);
        apb(OFF_CTRL_A, 1'b1, 32'hd1);
        wait_done;
        apb(OFF_CTRL_A, 1'b0, 32'h0);
        check("done when lost", 32'h1, r[CA_DONE]);
        apb(OFF_RESULT_HIGH, 1'b0, 32'h0);
        check("locked high", 32'h1a, r);
        apb(OFF_CTRL_A, 1'b1, 32'hd1);
        wait_done;
        apb(OFF_RESULT_LOW, 1'b0, 32'h0);
        check("unlocked low", 32'hc0, r);
        apb(OFF_RESULT_HIGH, 1'b0, 32'h0);
        check("new channel high", 32'h2a, r);
    endtask

    task automatic s_auto;
        apb(OFF_CTRL_B, 1'b1, 32'h1);
        apb(OFF_CTRL_A, 1'b1, 32'hb1);
        @(posedge pclk);
        trigger_in <= 8'h02;
        wait_done;
        check("auto length", 32'h1, (n >= 27 && n <= 36));
        check("auto sample", {26'h0, HALF_AUTO_SAMP + 6'd2}, s);
        repeat (80) begin
            @(posedge pclk);
            if (conversion_done === 1'b1) begin
                check("held level restart", 32'h0, 32'h1);
            end
        end
        trigger_in <= 8'h00;
        apb(OFF_CTRL_A, 1'b0, 32'h0);
        check("auto start clear", 32'h0, r[CA_START]);
    endtask

    task automatic s_free;
        apb(OFF_CTRL_B, 1'b1, {29'h0, TRIG_FREE_RUN});
        apb(OFF_CTRL_A, 1'b1, 32'hf1);
        wait_done;
        wait_done;
        check("free run length", 32'h1, (n >= 20 && n <= 32));
        apb(OFF_CTRL_A, 1'b0, 32'h0);
        check("free start held", 32'h1, r[CA_START]);
        apb(OFF_CTRL_A, 1'b1, 32'h0);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        finish_test;
    end

    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        trigger_in = 8'h00;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        s_reset;
        s_select;
        s_first;
        s_left;
        s_lock;
        s_auto;
        s_free;
        finish_test;
    end
endmodule
`default_nettype wire
